// ==== rtl/adccc_consts.svh ====
`ifndef ADCCC_CONSTS_SVH
`define ADCCC_CONSTS_SVH

// Phase lengths in converter clock cycles
`define ADCCC_SAMPLE_CYCLES   8'h05
`define ADCCC_CONV_CYCLES     8'h11
`define ADCCC_CAL_CYCLES      8'hA8
// Supply settling wait after power-up or power failure
`define ADCCC_SETTLE_CYCLES   42425
// Least calibrate pin low time
`define ADCCC_MIN_PULSE_NS    100
`define ADCCC_CLK_PERIOD_NS   10
`define ADCCC_MIN_PULSE_CYC   ((`ADCCC_MIN_PULSE_NS + `ADCCC_CLK_PERIOD_NS - 1) / `ADCCC_CLK_PERIOD_NS)
// Control register bit positions
`define ADCCC_CTL_LATCHED     0
`define ADCCC_CTL_CAL         1
`define ADCCC_CTL_EXTSAMPLE   2
`define ADCCC_CTL_PFCLR       5
// Reset value of the control register
`define ADCCC_CTL_RESET       8'h00
// Status bit position in the high byte
`define ADCCC_STATUS_BIT      7

`endif

// ==== rtl/adccc_control.sv ====
`timescale 1ns/1ps
`include "adccc_consts.svh"
// What this block does
// - Write strobe rise with select starts conversion
// - Five sample cycles, then twelve decision cycles
// - Busy low through the whole conversion
// - External sample edge starts conversion when enabled
// - Self calibration after power-up and power failure
// - Calibrate pin low pulse rise starts calibration when external sampling is off
// - Control bit 1 written high starts calibration
// - Calibration request abandons running conversion
// - Conversion starts ignored during calibration
// - Calibration 168 cycles then one conversion
// - Wait 42425 cycles before automatic calibration
// - Register select high reads control register; writes also need byte select high
// - Low byte carries result bits 7 to 0
// - High byte lines 3 to 0 carry bits 11-8
// - High byte lines 6 to 4 driven low
// - High byte line 7 is inverted busy
// - Channel address latched on write or select rise
module adccc_control #(
  parameter int unsigned SETTLE_CYCLES = `ADCCC_SETTLE_CYCLES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire adccc_pkg::adccc_bus_t busIn,
  input  wire logic [7:0]           dataIn,
  input  wire logic                 calibrateN,
  input  wire logic                 powerFail,
  input  wire logic                 comparatorOut,
  input  wire logic                 calOverflow,
  output adccc_pkg::adccc_drive_t   busOut,
  output logic                      busyN,
  output logic [1:0]                channelSel,
  output logic                      sampleActive,
  output logic                      calActive,
  output logic                      latchedMode,
  output logic                      powerFailFlag,
  output logic                      calError
);

  typedef struct packed {
    adccc_pkg::adccc_phase_t phase;
    logic [7:0]              cycle;
    logic                    calFollow;
    logic [11:0]             sar;
    logic [11:0]             result;
    logic [1:0]              channel;
    logic [7:0]              ctl;
    logic                    pfFlag;
    logic                    calErr;
    logic                    selWr;
    logic [7:0]              calLowCnt;
    adccc_pkg::adccc_drive_t drive;
  } adccc_ctl_state_t;

  adccc_ctl_state_t state_r;
  adccc_ctl_state_t state_nxt;

  logic settleDone;
  logic calPinRise;
  logic selWrNow;
  logic writeRise;
  logic selRise;
  logic sfrWrite;
  logic dataWrite;
  logic calRequest;
  logic convRequest;
  logic inCal;
  logic [7:0] readByte;

  // Builds the byte presented for a read
  function automatic logic [7:0] adccc_read_byte(
    input logic        regSel,
    input logic        hiByte,
    input logic [11:0] res,
    input logic [7:0]  ctl,
    input logic        pf,
    input logic        cerr,
    input logic        busy
  );
    logic [7:0] b;
    b = 8'h00;
    if (regSel) begin
      b = {2'h0, ~pf, 2'h0, ctl[2:0]};
      b[6] = cerr;
    end else if (hiByte) begin
      b = {busy, 3'h0, res[11:8]};
    end else begin
      b = res[7:0];
    end
    return b;
  endfunction

  // Settling wait before any automatic calibration
  adccc_settle_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .restart (powerFail),
    .done    (settleDone)
  );

  // Shared calibrate / sample-control pin edge
  adccc_edge_detect u_calEdge (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .level   (calibrateN),
    .rise    (calPinRise)
  );

  // Write window is select and write both low; its end is the start event
  assign selWrNow  = ~busIn.csN & ~busIn.wrN;
  assign writeRise = state_r.selWr & ~selWrNow;
  assign selRise   = writeRise;
  assign sfrWrite  = writeRise & busIn.registerSelect & busIn.byteSelect;
  assign dataWrite = writeRise & ~busIn.registerSelect;
  assign inCal     = (state_r.phase == adccc_pkg::ADCCC_CAL) | state_r.calFollow;

  // A pin pulse only counts as calibrate when long enough and not in sample mode.
  // The pin's first high cycle is used, since the low counter clears one cycle later.
  assign calRequest = settleDone
                    | (calibrateN & ~state_r.ctl[`ADCCC_CTL_EXTSAMPLE]
                       & (state_r.calLowCnt >= 8'(`ADCCC_MIN_PULSE_CYC)))
                    | (sfrWrite & dataIn[`ADCCC_CTL_CAL]);
  assign convRequest = ~inCal & (dataWrite
                    | (calPinRise & state_r.ctl[`ADCCC_CTL_EXTSAMPLE]));

  always_comb begin
    state_nxt       = state_r;
    state_nxt.selWr = selWrNow;
    readByte = adccc_read_byte(busIn.registerSelect, busIn.byteSelect, state_r.result,
                               state_r.ctl, state_r.pfFlag, state_r.calErr,
                               state_r.phase != adccc_pkg::ADCCC_IDLE);

    // Low time of the calibrate pin, saturating
    if (calibrateN) begin
      state_nxt.calLowCnt = 8'h00;
    end else if (state_r.calLowCnt != 8'hFF) begin
      state_nxt.calLowCnt = state_r.calLowCnt + 8'h01;
    end

    // Channel address latched when the write window closes
    if (selRise & ~inCal & ~busIn.registerSelect) begin
      state_nxt.channel = {busIn.channelAddrMsb, busIn.channelAddrLsb};
    end

    // Control register writes; calibrate bit is a command, not stored
    if (sfrWrite) begin
      state_nxt.ctl = dataIn & 8'h05;
      if (!dataIn[`ADCCC_CTL_PFCLR]) begin
        state_nxt.pfFlag = 1'b0;
      end
    end
    // Power failure sets the flag and drops written settings; set wins
    if (powerFail) begin
      state_nxt.pfFlag = 1'b1;
      state_nxt.ctl    = `ADCCC_CTL_RESET;
    end

    // Phase sequencer
    unique case (state_r.phase)
      adccc_pkg::ADCCC_IDLE: begin
        state_nxt.cycle = 8'h00;
      end
      adccc_pkg::ADCCC_SAMPLE: begin
        state_nxt.cycle = state_r.cycle + 8'h01;
        if (state_r.cycle == `ADCCC_SAMPLE_CYCLES - 8'h01) begin
          state_nxt.phase = adccc_pkg::ADCCC_CONV;
          state_nxt.sar   = 12'h000;
        end
      end
      adccc_pkg::ADCCC_CONV: begin
        state_nxt.cycle = state_r.cycle + 8'h01;
        // One decision per cycle, most significant bit first
        state_nxt.sar = {state_r.sar[10:0], comparatorOut};
        if (!state_r.ctl[`ADCCC_CTL_LATCHED]) begin
          state_nxt.result = {state_r.sar[10:0], comparatorOut};
        end
        if (state_r.cycle == `ADCCC_CONV_CYCLES - 8'h01) begin
          state_nxt.phase     = adccc_pkg::ADCCC_IDLE;
          state_nxt.calFollow = 1'b0;
          state_nxt.result    = {state_r.sar[10:0], comparatorOut};
        end
      end
      adccc_pkg::ADCCC_CAL: begin
        state_nxt.cycle = state_r.cycle + 8'h01;
        if (calOverflow) begin
          state_nxt.calErr = 1'b1;
        end
        if (state_r.cycle == `ADCCC_CAL_CYCLES - 8'h01) begin
          state_nxt.phase     = adccc_pkg::ADCCC_SAMPLE;
          state_nxt.cycle     = 8'h00;
          state_nxt.calFollow = 1'b1;
        end
      end
      default: begin
        state_nxt.phase = adccc_pkg::ADCCC_IDLE;
      end
    endcase

    // Calibration overrides anything in progress
    if (calRequest) begin
      state_nxt.phase     = adccc_pkg::ADCCC_CAL;
      state_nxt.cycle     = 8'h00;
      state_nxt.calErr    = 1'b0;
      state_nxt.calFollow = 1'b0;
    end else if (convRequest) begin
      // External edge ends sampling at once; a write restarts the sequence
      if (calPinRise & state_r.ctl[`ADCCC_CTL_EXTSAMPLE]) begin
        state_nxt.phase = adccc_pkg::ADCCC_CONV;
        state_nxt.cycle = `ADCCC_SAMPLE_CYCLES;
        state_nxt.sar   = 12'h000;
      end else begin
        state_nxt.phase = adccc_pkg::ADCCC_SAMPLE;
        state_nxt.cycle = 8'h00;
      end
    end

    // Byte bus drive, registered from the current pin levels
    state_nxt.drive.data = readByte;
    if (~busIn.csN & ~busIn.rdN) begin
      state_nxt.drive.oeN = 8'h00;
    end else begin
      state_nxt.drive.oeN = 8'hFF;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r           <= '0;
      state_r.phase     <= adccc_pkg::ADCCC_IDLE;
      state_r.ctl       <= `ADCCC_CTL_RESET;
      state_r.pfFlag    <= 1'b1;
      state_r.drive.oeN <= 8'hFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Busy registered from the next phase, in step with the phase register: low in any non-idle phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busyN        <= 1'b1;
      channelSel   <= 2'h0;
      sampleActive <= 1'b0;
      calActive    <= 1'b0;
    end else begin
      busyN        <= state_nxt.phase == adccc_pkg::ADCCC_IDLE;
      channelSel   <= state_nxt.channel;
      sampleActive <= state_nxt.phase == adccc_pkg::ADCCC_SAMPLE;
      calActive    <= state_nxt.phase == adccc_pkg::ADCCC_CAL;
    end
  end

  assign busOut        = state_r.drive;
  assign latchedMode   = state_r.ctl[`ADCCC_CTL_LATCHED];
  assign powerFailFlag = state_r.pfFlag;
  assign calError      = state_r.calErr;

endmodule

// ==== rtl/adccc_edge_detect.sv ====
`timescale 1ns/1ps
// Rising edge detector for a synchronous pin
module adccc_edge_detect (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      rise
);

  typedef struct packed {
    logic prev;
    logic rise;
  } adccc_edge_state_t;

  adccc_edge_state_t state_r;
  adccc_edge_state_t state_nxt;

  // Idle-high reset value so a pin held high at release is no edge
  always_comb begin
    state_nxt      = state_r;
    state_nxt.prev = level;
    state_nxt.rise = level & ~state_r.prev;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= 2'h2;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rise = state_r.rise;

endmodule

// ==== rtl/adccc_pkg.sv ====
package adccc_pkg;

  typedef enum logic [3:0] {
    ADCCC_IDLE   = 4'b0001,
    ADCCC_SAMPLE = 4'b0010,
    ADCCC_CONV   = 4'b0100,
    ADCCC_CAL    = 4'b1000
  } adccc_phase_t;

  // Microprocessor bus pins as seen by the device
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic byteSelect;
    logic registerSelect;
    logic channelAddrMsb;
    logic channelAddrLsb;
  } adccc_bus_t;

  // Byte bus drive toward the pins
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oeN;
  } adccc_drive_t;

endpackage

// ==== rtl/adccc_settle_timer.sv ====
`timescale 1ns/1ps
`include "adccc_consts.svh"
// Counts the supply settling wait, restarted by power failure
module adccc_settle_timer #(
  parameter int unsigned SETTLE_CYCLES = `ADCCC_SETTLE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      done
);

  typedef struct packed {
    logic [15:0] count;
    logic        running;
    logic        done;
  } adccc_settle_state_t;

  adccc_settle_state_t state_r;
  adccc_settle_state_t state_nxt;

  // Runs from reset; done is a one-cycle pulse after the full wait
  always_comb begin
    state_nxt      = state_r;
    state_nxt.done = 1'b0;
    if (restart) begin
      state_nxt.count   = 16'h0000;
      state_nxt.running = 1'b1;
    end else if (state_r.running) begin
      if (state_r.count == 16'(SETTLE_CYCLES - 1)) begin
        state_nxt.running = 1'b0;
        state_nxt.done    = 1'b1;
      end else begin
        state_nxt.count = state_r.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= {16'h0000, 1'b1, 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign done = state_r.done;

endmodule

// ==== tb/adccc_control_props.sv ====
`timescale 1ns/1ps
// Port checker for the converter control block
module adccc_control_props #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  input wire adccc_pkg::adccc_bus_t   busIn,
  input wire logic [7:0]              dataIn,
  input wire logic                    calibrateN,
  input wire logic                    powerFail,
  input wire adccc_pkg::adccc_drive_t busOut,
  input wire logic                    busyN,
  input wire logic [1:0]              channelSel,
  input wire logic                    sampleActive,
  input wire logic                    calActive
);
  localparam int SETTLE_MAX = SETTLE_CYCLES + 8;
  logic       wrLow_r;
  logic [7:0] calCnt_r;
  logic       wrTaken;
  logic       hiRead;
  // Strobe history and calibration length; the counter saturates nowhere, cal is short
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrLow_r  <= 1'b0;
      calCnt_r <= 8'h00;
    end else begin
      wrLow_r  <= !busIn.csN && !busIn.wrN;
      calCnt_r <= calActive ? calCnt_r + 8'h01 : 8'h00;
    end
  end
  // A write is taken when its strobe window closes
  assign wrTaken = wrLow_r && !(!busIn.csN && !busIn.wrN);
  assign hiRead  = !busIn.csN && !busIn.rdN && busIn.byteSelect && !busIn.registerSelect;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence convRun;
    (!busyN && sampleActive)[*5] ##1 (!busyN && !sampleActive)[*8] ##1 !busyN[*4] ##1 busyN;
  endsequence
  // Calibrate pin low may abort a conversion, so attempts stop there
  a_conv_sequence: assert property (disable iff (!reset_n || !calibrateN)
    wrTaken && !busIn.registerSelect && busyN && !calActive |=> convRun)
    else $error("conversion sequence broken");
  a_addr_latch: assert property (wrTaken && !busIn.registerSelect && busyN && !calActive
    |=> channelSel == {$past(busIn.channelAddrMsb), $past(busIn.channelAddrLsb)})
    else $error("channel not latched");
  a_status_inverse: assert property (hiRead ##1 (hiRead && $stable(busyN))
    |-> busOut.data[7] == !busyN) else $error("status bit not inverse of busy");
  a_high_zero: assert property (hiRead ##1 hiRead |-> busOut.data[6:4] == 3'h0)
    else $error("high byte middle bits not low");
  a_read_drive: assert property (!busIn.csN && !busIn.rdN |=> busOut.oeN == 8'h00)
    else $error("read not driven");
  a_idle_float: assert property (!(!busIn.csN && !busIn.rdN) |=> busOut.oeN == 8'hFF)
    else $error("data driven outside read");
  a_cal_length: assert property ($fell(calActive) |-> calCnt_r == 8'hA8)
    else $error("calibration length wrong");
  a_cal_then_conv: assert property ($fell(calActive)
    |-> !busyN[*8] ##1 !busyN[*8] ##[1:3] busyN) else $error("no conversion after cal");
  a_cal_command: assert property (wrTaken && busIn.registerSelect && busIn.byteSelect
    && dataIn[1] |=> calActive && !busyN) else $error("cal command ignored");
  a_cal_no_sample: assert property (calActive |-> !sampleActive)
    else $error("sampling during calibration");
  a_pfail_wait: assert property ($fell(powerFail)
    |-> !calActive[*8] ##[1:SETTLE_MAX] calActive) else $error("no cal after power fail");
endmodule

bind adccc_control adccc_control_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) props_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .busIn(busIn), .dataIn(dataIn),
  .calibrateN(calibrateN), .powerFail(powerFail), .busOut(busOut), .busyN(busyN),
  .channelSel(channelSel), .sampleActive(sampleActive), .calActive(calActive));

// ==== tb/adccc_control_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the converter control block
module adccc_control_tb;
  localparam int SETTLE = 20;
  logic                    clk_sys;
  logic                    reset_n;
  logic                    calibrateN;
  logic                    powerFail;
  logic                    comparatorOut;
  logic                    calOverflow;
  adccc_pkg::adccc_bus_t   busIn;
  logic [7:0]              dataIn;
  adccc_pkg::adccc_drive_t busOut;
  logic                    busyN;
  logic [1:0]              channelSel;
  logic                    sampleActive;
  logic                    calActive;
  logic                    powerFailFlag;
  logic [7:0]              rdData;
  logic [7:0]              rdOe;
  int                      failCount = 0;
  int                      checkCount = 0;

  adccc_control #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .busIn(busIn), .dataIn(dataIn),
    .calibrateN(calibrateN), .powerFail(powerFail), .comparatorOut(comparatorOut),
    .calOverflow(calOverflow), .busOut(busOut), .busyN(busyN), .channelSel(channelSel),
    .sampleActive(sampleActive), .calActive(calActive), .latchedMode(),
    .powerFailFlag(powerFailFlag), .calError());
  adccc_host host (.clk_sys(clk_sys), .busOut(busOut), .busIn(busIn), .dataIn(dataIn));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait for busy high (w=0) or calibration running (w=1)
  task automatic await(input int w, input int lim);
    int n;
    n = 0;
    while (((w == 0) ? busyN !== 1'b1 : calActive !== 1'b1) && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk({7'h00, n < lim}, 8'h01);
  endtask
  task automatic busyEnd(input int lim);
    repeat (2) @(posedge clk_sys);
    await(0, lim);
  endtask
  // Main sequence
  initial begin
    reset_n       = 1'b0;
    calibrateN    = 1'b1;
    powerFail     = 1'b0;
    comparatorOut = 1'b1;
    calOverflow   = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk({7'h00, powerFailFlag}, 8'h01);
    await(1, SETTLE + 10);
    busyEnd(220);
    host.rd(1'b0, 1'b0, rdData, rdOe);
    chk(rdData, 8'hFF);
    chk(rdOe, 8'h00);
    host.rd(1'b0, 1'b1, rdData, rdOe);
    chk(rdData, 8'h0F);
    // Plain conversion on channel 2, every decision low
    comparatorOut <= 1'b0;
    host.wr(1'b0, 1'b0, 2'h2, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({6'h00, channelSel}, 8'h02);
    host.rd(1'b0, 1'b1, rdData, rdOe);
    chk(rdData & 8'hF0, 8'h80);
    await(0, 40);
    host.rd(1'b0, 1'b0, rdData, rdOe);
    chk(rdData, 8'h00);
    host.rd(1'b0, 1'b1, rdData, rdOe);
    chk(rdData, 8'h00);
    // Calibrate pulse lands mid-conversion
    fork
      host.wr(1'b0, 1'b0, 2'h1, 8'h00);
      begin
        calibrateN <= 1'b0;
        repeat (14) @(posedge clk_sys);
        calibrateN <= 1'b1;
      end
    join
    await(1, 5);
    host.wr(1'b0, 1'b0, 2'h3, 8'h00);
    chk({7'h00, calActive}, 8'h01);
    busyEnd(220);
    // Command calibration with overflow; D5 low also clears the power flag
    calOverflow <= 1'b1;
    host.wr(1'b1, 1'b1, 2'h0, 8'h02);
    await(1, 5);
    busyEnd(220);
    calOverflow <= 1'b0;
    host.rd(1'b1, 1'b1, rdData, rdOe);
    chk(rdData & 8'hE5, 8'h60);
    // External sample edge starts a conversion
    host.wr(1'b1, 1'b1, 2'h0, 8'h04);
    calibrateN <= 1'b0;
    repeat (12) @(posedge clk_sys);
    calibrateN <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({6'h00, busyN, calActive}, 8'h00);
    await(0, 40);
    // Latched mode keeps the old result until the conversion ends
    host.wr(1'b1, 1'b1, 2'h0, 8'h01);
    comparatorOut <= 1'b1;
    host.wr(1'b0, 1'b0, 2'h0, 8'h00);
    repeat (8) @(posedge clk_sys);
    host.rd(1'b0, 1'b0, rdData, rdOe);
    chk(rdData, 8'h00);
    await(0, 40);
    host.rd(1'b0, 1'b0, rdData, rdOe);
    chk(rdData, 8'hFF);
    // Power failure: flag, settle wait, then calibration
    powerFail <= 1'b1;
    repeat (2) @(posedge clk_sys);
    powerFail <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({6'h00, powerFailFlag, calActive}, 8'h02);
    await(1, SETTLE + 10);
    busyEnd(220);
    reportAndStop();
  end
  // Watchdog well beyond the expected one thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    reportAndStop();
  end
endmodule

// ==== tb/adccc_host.sv ====
`timescale 1ns/1ps
// Host processor side of the byte bus
module adccc_host (
  input  wire logic                    clk_sys,
  input  wire adccc_pkg::adccc_drive_t busOut,
  output adccc_pkg::adccc_bus_t        busIn,
  output logic [7:0]                   dataIn
);
  // All strobes idle high
  initial begin
    busIn  = 7'h70;
    dataIn = 8'h00;
  end
  // Write cycle; address and selects stay put after release so the taking edge sees them
  task automatic wr(input logic rs, input logic hb, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busIn  <= {3'b010, hb, rs, a};
    dataIn <= d;
    repeat (10) @(posedge clk_sys);
    busIn.csN <= 1'b1;
    busIn.wrN <= 1'b1;
    @(posedge clk_sys);
    dataIn <= ~d; // Released lines must not look held
  endtask
  // Read cycle; data lags the strobes by one cycle
  task automatic rd(input logic rs, input logic hb, output logic [7:0] d, output logic [7:0] oe);
    @(posedge clk_sys);
    busIn <= {3'b001, hb, rs, busIn[1:0]};
    repeat (2) @(posedge clk_sys);
    d  = busOut.data;
    oe = busOut.oeN;
    busIn.csN <= 1'b1;
    busIn.rdN <= 1'b1;
  endtask
endmodule
